// ===== rtl/irpmc_defs.vh
// constants for the initial reset and power mode control block
// assumes a 250 MHz system clock and a 32.768 kHz low-speed oscillator
`ifndef IRPMC_DEFS_VH
`define IRPMC_DEFS_VH

// ----------------------------------------
// clock rates
// ----------------------------------------
`define IRPMC_CLK_MHZ 250
`define IRPMC_CLK_HZ 250000000
`define IRPMC_OSC_HZ 32768
// system cycles per oscillator cycle, truncated
`define IRPMC_OSC_DIV 24'd7629

// ----------------------------------------
// timing figures and derived counts
// ----------------------------------------
`define IRPMC_NOISE_NS 100
// noise window in system cycles, rounded up
`define IRPMC_NOISE_CYC 8'd25
`define IRPMC_TICK_HZ 2
// oscillator cycles per 2 Hz half period
`define IRPMC_TICK_HALF 24'd8192
`define IRPMC_RELEASE_MS 250
`define IRPMC_KEY_NR_US 1500
// key noise window in oscillator cycles, rounded up
`define IRPMC_KEY_NR_TICKS 24'd50
`define IRPMC_QUAL_MS 1000
// qualifying time in oscillator cycles
`define IRPMC_QUAL_TICKS 24'd32768

// ----------------------------------------
// key combination select codes
// ----------------------------------------
`define IRPMC_KEY_OFF 2'h0
`define IRPMC_KEY_01 2'h1
`define IRPMC_KEY_012 2'h2
`define IRPMC_KEY_0123 2'h3

// ----------------------------------------
// reset values
// ----------------------------------------
`define IRPMC_PC_RESET 16'h0110
`define IRPMC_LCD_LEVEL_RESET 4'h0
`define IRPMC_CNT_W 24

`endif

// ===== rtl/irpmc_key_qual.v
// key combination reset: combination match, noise rejector, qualifying timer
// assumes key inputs already synchronised and a one-cycle oscillator tick
`timescale 1ns/1ps
`include "irpmc_defs.vh"

module irpmc_key_qual #(
  parameter [`IRPMC_CNT_W-1:0] NR_TICKS = `IRPMC_KEY_NR_TICKS,
  parameter [`IRPMC_CNT_W-1:0] QUAL_TICKS = `IRPMC_QUAL_TICKS
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire osc_tick_i,
  input wire osc_running_i,
  input wire [1:0] key_combo_sel_i,
  input wire [3:0] key_input_i,
  output reg key_reset_o
);

  // ----------------------------------------
  // combination decode
  // ----------------------------------------
  function combo_match;
    input [1:0] sel;
    input [3:0] keys;
    begin
      case (sel)
        `IRPMC_KEY_01: combo_match = keys[0] & keys[1];
        `IRPMC_KEY_012: combo_match = &keys[2:0];
        `IRPMC_KEY_0123: combo_match = &keys;
        default: combo_match = 1'b0;
      endcase
    end
  endfunction

  reg [`IRPMC_CNT_W-1:0] nr_cnt_reg;
  reg [`IRPMC_CNT_W-1:0] qual_cnt_reg;
  wire match;
  wire nr_done;

  assign match = combo_match(key_combo_sel_i, key_input_i);
  assign nr_done = (nr_cnt_reg >= NR_TICKS);

  // ----------------------------------------
  // noise rejector and qualifying timer
  // ----------------------------------------
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nr_cnt_reg <= {`IRPMC_CNT_W{1'b0}};
      qual_cnt_reg <= {`IRPMC_CNT_W{1'b0}};
      key_reset_o <= 1'b0;
    end else if (!match) begin
      nr_cnt_reg <= {`IRPMC_CNT_W{1'b0}};
      qual_cnt_reg <= {`IRPMC_CNT_W{1'b0}};
      key_reset_o <= 1'b0;
    end else if (osc_tick_i && osc_running_i) begin
      if (!nr_done) begin
        nr_cnt_reg <= nr_cnt_reg + {{(`IRPMC_CNT_W-1){1'b0}}, 1'b1};
      end else if (qual_cnt_reg < QUAL_TICKS) begin
        qual_cnt_reg <= qual_cnt_reg + {{(`IRPMC_CNT_W-1){1'b0}}, 1'b1};
      end else begin
        key_reset_o <= 1'b1;
      end
    end
  end

endmodule // irpmc_key_qual

// ===== rtl/irpmc_top.v
// initial reset latch, cpu reset state and supply mode control
// pins may be asynchronous to sys_clk_i and are synchronised here; firmware strobes are one-cycle pulses
`timescale 1ns/1ps
`include "irpmc_defs.vh"

module irpmc_top #(
  parameter [`IRPMC_CNT_W-1:0] OSC_DIV = `IRPMC_OSC_DIV,
  parameter [`IRPMC_CNT_W-1:0] TICK_HALF = `IRPMC_TICK_HALF,
  parameter [`IRPMC_CNT_W-1:0] KEY_NR_TICKS = `IRPMC_KEY_NR_TICKS,
  parameter [`IRPMC_CNT_W-1:0] QUAL_TICKS = `IRPMC_QUAL_TICKS
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire reset_pin_i,
  input wire [3:0] key_input_i,
  input wire [1:0] key_combo_sel_i,
  input wire osc_running_i,
  input wire high_speed_active_i,
  input wire int_enable_set_i,
  input wire int_enable_clr_i,
  input wire wide_stack_pointer_wr_i,
  input wire narrow_stack_pointer_wr_i,
  input wire extension_register_wr_i,
  input wire instr_done_i,
  input wire core_supply_wr_i,
  input wire core_supply_high_i,
  input wire lsr_halver_wr_i,
  input wire lsr_halver_i,
  input wire lcd_halver_wr_i,
  input wire lcd_halver_i,
  input wire lcd_ctrl_wr_i,
  input wire lcd_on_i,
  input wire [3:0] lcd_level_i,
  output reg init_reset_o,
  output reg two_hz_o,
  output reg [15:0] pc_start_o,
  output reg int_enable_o,
  output reg int_unmask_o,
  output reg extension_flag_o,
  output reg core_supply_rail_high_o,
  output reg lsr_halver_o,
  output reg lcd_halver_o,
  output reg lcd_base_voltage_on_o,
  output reg [3:0] lcd_base_voltage_level_o
);

  localparam [`IRPMC_CNT_W-1:0] ONE = {{(`IRPMC_CNT_W-1){1'b0}}, 1'b1};
  localparam [7:0] NOISE_CYC = `IRPMC_NOISE_CYC;

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  reg pin_meta_reg;
  reg pin_sync_reg;
  wire [3:0] key_sync;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end else begin
      pin_meta_reg <= reset_pin_i;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_key_sync
      reg meta_reg;
      reg sync_reg;
      always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= key_input_i[k];
          sync_reg <= meta_reg;
        end
      end
      assign key_sync[k] = sync_reg;
    end
  endgenerate

  // ----------------------------------------
  // pin noise filter
  // ----------------------------------------
  reg [7:0] pin_cnt_reg;
  reg pin_high_reg;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_cnt_reg <= 8'h00;
      pin_high_reg <= 1'b0;
    end else if (!pin_sync_reg) begin
      pin_cnt_reg <= 8'h00;
      pin_high_reg <= 1'b0;
    end else if (pin_cnt_reg < NOISE_CYC - 8'h01) begin
      pin_cnt_reg <= pin_cnt_reg + 8'h01;
    end else begin
      pin_high_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // oscillator tick and 2 Hz divider
  // ----------------------------------------
  reg [`IRPMC_CNT_W-1:0] osc_cnt_reg;
  reg osc_tick_reg;
  reg [`IRPMC_CNT_W-1:0] half_cnt_reg;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_cnt_reg <= {`IRPMC_CNT_W{1'b0}};
      osc_tick_reg <= 1'b0;
    end else if (osc_cnt_reg >= OSC_DIV - ONE) begin
      osc_cnt_reg <= {`IRPMC_CNT_W{1'b0}};
      osc_tick_reg <= 1'b1;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + ONE;
      osc_tick_reg <= 1'b0;
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      half_cnt_reg <= {`IRPMC_CNT_W{1'b0}};
      two_hz_o <= 1'b0;
    end else if (osc_tick_reg) begin
      if (half_cnt_reg >= TICK_HALF - ONE) begin
        half_cnt_reg <= {`IRPMC_CNT_W{1'b0}};
        two_hz_o <= ~two_hz_o;
      end else begin
        half_cnt_reg <= half_cnt_reg + ONE;
      end
    end
  end

  // ----------------------------------------
  // key combination reset
  // ----------------------------------------
  wire key_reset;

  irpmc_key_qual #(
    .NR_TICKS(KEY_NR_TICKS),
    .QUAL_TICKS(QUAL_TICKS)
  ) u_key_qual (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .osc_tick_i(osc_tick_reg),
    .osc_running_i(osc_running_i),
    .key_combo_sel_i(key_combo_sel_i),
    .key_input_i(key_sync),
    .key_reset_o(key_reset)
  );

  // ----------------------------------------
  // initial reset latch
  // ----------------------------------------
  wire latch_set;

  assign latch_set = pin_high_reg | key_reset;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_reset_o <= 1'b1;
    end else if (latch_set) begin
      init_reset_o <= 1'b1;
    end else if (two_hz_o) begin
      init_reset_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // cpu reset state
  // ----------------------------------------
  reg wsp_set_reg;
  reg nsp_set_reg;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_start_o <= `IRPMC_PC_RESET;
      int_enable_o <= 1'b0;
      extension_flag_o <= 1'b0;
    end else if (init_reset_o) begin
      pc_start_o <= `IRPMC_PC_RESET;
      int_enable_o <= 1'b0;
      extension_flag_o <= 1'b0;
    end else begin
      pc_start_o <= `IRPMC_PC_RESET;
      if (int_enable_set_i) begin
        int_enable_o <= 1'b1;
      end else if (int_enable_clr_i) begin
        int_enable_o <= 1'b0;
      end
      if (extension_register_wr_i) begin
        extension_flag_o <= 1'b1;
      end else if (instr_done_i) begin
        extension_flag_o <= 1'b0;
      end
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wsp_set_reg <= 1'b0;
      nsp_set_reg <= 1'b0;
      int_unmask_o <= 1'b0;
    end else if (init_reset_o) begin
      wsp_set_reg <= 1'b0;
      nsp_set_reg <= 1'b0;
      int_unmask_o <= 1'b0;
    end else if (wide_stack_pointer_wr_i && narrow_stack_pointer_wr_i) begin
      wsp_set_reg <= 1'b1;
      nsp_set_reg <= 1'b1;
      int_unmask_o <= 1'b1;
    end else if (wide_stack_pointer_wr_i) begin
      wsp_set_reg <= 1'b1;
      nsp_set_reg <= nsp_set_reg & ~int_unmask_o;
      int_unmask_o <= nsp_set_reg & ~int_unmask_o;
    end else if (narrow_stack_pointer_wr_i) begin
      nsp_set_reg <= 1'b1;
      wsp_set_reg <= wsp_set_reg & ~int_unmask_o;
      int_unmask_o <= wsp_set_reg & ~int_unmask_o;
    end
  end

  // ----------------------------------------
  // halver write decode
  // ----------------------------------------
  function halver_ok;
    input hs;
    input req;
    begin
      halver_ok = !(hs && req);
    end
  endfunction

  // ----------------------------------------
  // supply mode control
  // ----------------------------------------
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_supply_rail_high_o <= 1'b0;
      lsr_halver_o <= 1'b0;
      lcd_halver_o <= 1'b0;
      lcd_base_voltage_on_o <= 1'b0;
      lcd_base_voltage_level_o <= `IRPMC_LCD_LEVEL_RESET;
    end else if (init_reset_o) begin
      core_supply_rail_high_o <= 1'b0;
      lsr_halver_o <= 1'b0;
      lcd_halver_o <= 1'b0;
      lcd_base_voltage_on_o <= 1'b0;
      lcd_base_voltage_level_o <= `IRPMC_LCD_LEVEL_RESET;
    end else begin
      if (core_supply_wr_i) begin
        core_supply_rail_high_o <= core_supply_high_i;
      end
      if (lsr_halver_wr_i && halver_ok(high_speed_active_i, lsr_halver_i)) begin
        lsr_halver_o <= lsr_halver_i;
      end
      if (lcd_halver_wr_i && halver_ok(high_speed_active_i, lcd_halver_i)) begin
        lcd_halver_o <= lcd_halver_i;
      end
      if (lcd_ctrl_wr_i) begin
        lcd_base_voltage_on_o <= lcd_on_i;
        lcd_base_voltage_level_o <= lcd_level_i;
      end
    end
  end

endmodule // irpmc_top

// ===== verif/irpmc_assertions.sv
// checker for the initial reset and power mode block
// assumes the reduced tick counts that the bench sets
`timescale 1ns/1ps
module irpmc_chk (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire reset_pin_i,
  input wire [1:0] key_combo_sel_i,
  input wire high_speed_active_i,
  input wire extension_register_wr_i,
  input wire lsr_halver_wr_i,
  input wire lsr_halver_i,
  input wire lcd_halver_wr_i,
  input wire lcd_halver_i,
  input wire lcd_ctrl_wr_i,
  input wire lcd_on_i,
  input wire [3:0] lcd_level_i,
  input wire init_reset_o,
  input wire two_hz_o,
  input wire [15:0] pc_start_o,
  input wire int_enable_o,
  input wire int_unmask_o,
  input wire extension_flag_o,
  input wire lsr_halver_o,
  input wire lcd_halver_o,
  input wire lcd_base_voltage_on_o,
  input wire [3:0] lcd_base_voltage_level_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------
  // pin high run length
  // ----------------------------------------
  reg [5:0] pin_cnt_reg;
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) pin_cnt_reg <= 6'h00;
    else if (!reset_pin_i) pin_cnt_reg <= 6'h00;
    else if (pin_cnt_reg != 6'h3F) pin_cnt_reg <= pin_cnt_reg + 6'h01;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_pin_sets_reset:
    assert property (pin_cnt_reg == 6'h1F |-> init_reset_o) else $error("long pin pulse gave no reset");
  a_short_pulse_ignored:
    assert property ($fell(reset_pin_i) && $past(pin_cnt_reg) < 6'h14 && !init_reset_o && key_combo_sel_i == 2'h0
      |=> !init_reset_o [*8]) else $error("short pin pulse gave a reset");
  a_release_on_tick:
    assert property ($fell(init_reset_o) |-> $past(two_hz_o) || two_hz_o) else $error("release outside tick high");
  a_pc_start_value:
    assert property (pc_start_o == 16'h0110) else $error("wrong start address");
  a_reset_masks_int:
    assert property (init_reset_o ##1 init_reset_o |-> !int_enable_o && !int_unmask_o) else $error("int not cleared");
  a_reset_normal_mode:
    assert property (init_reset_o ##1 init_reset_o |-> !lsr_halver_o && !lcd_halver_o) else $error("halver in reset");
  a_halver_refused:
    assert property (high_speed_active_i && lsr_halver_wr_i && lsr_halver_i && !lsr_halver_o |=> !lsr_halver_o)
      else $error("halver set at high speed");
  a_ext_flag_set:
    assert property (extension_register_wr_i && !init_reset_o && !$past(init_reset_o)
      |=> extension_flag_o || init_reset_o) else $error("extension flag not set");
  a_lcd_write:
    assert property (lcd_ctrl_wr_i && !init_reset_o && !$past(init_reset_o) |=> init_reset_o ||
      (lcd_base_voltage_on_o == $past(lcd_on_i) && lcd_base_voltage_level_o == $past(lcd_level_i)))
      else $error("lcd control not taken");
  a_lcd_halver_refused:
    assert property (high_speed_active_i && lcd_halver_wr_i && lcd_halver_i && !lcd_halver_o |=> !lcd_halver_o)
      else $error("lcd halver set at high speed");
  a_two_hz_steady:
    assert property ($changed(two_hz_o) |=> $stable(two_hz_o) [*8]) else $error("2 Hz phase too short");
endmodule // irpmc_chk

bind irpmc_top irpmc_chk u_chk (.*);

// ===== verif/irpmc_ext_model.sv
// far-side model: reset pin source and key switches
// assumes tasks are called just after a rising edge
`timescale 1ns/1ps
module irpmc_ext_model (
  input wire sys_clk_i,
  output logic reset_pin_o,
  output logic [3:0] key_o
);
  initial begin
    reset_pin_o = 1'b0;
    key_o = 4'h0;
  end
  task automatic pin(input logic v, input int n);
    reset_pin_o = v;
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic keys(input logic [3:0] v, input int n);
    key_o = v;
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
endmodule // irpmc_ext_model

// ===== verif/tb_initial_reset_and_power_mode_control.sv
// self-checking bench for the initial reset and power mode block
// assumes a 250 MHz clock and reduced tick counts
`timescale 1ns/1ps
module tb_initial_reset_and_power_mode_control;
  logic sys_clk_i, rst_n_i, osc_running_i, high_speed_active_i, core_supply_high_i;
  logic lsr_halver_i, lcd_halver_i, lcd_on_i;
  logic [1:0] key_combo_sel_i;
  logic [3:0] lcd_level_i, km;
  logic [9:0] stb;
  logic [11:0] e;
  logic [27:0] q[$];
  int err_count, samples_checked, seed, s;
  int cyc = 0;
  wire reset_pin_i, init_reset_o, two_hz_o, int_enable_o, int_unmask_o, extension_flag_o;
  wire core_supply_rail_high_o, lsr_halver_o, lcd_halver_o, lcd_base_voltage_on_o;
  wire [3:0] key_input_i, lcd_base_voltage_level_o;
  wire [15:0] pc_start_o;
  irpmc_ext_model m (.sys_clk_i(sys_clk_i), .reset_pin_o(reset_pin_i), .key_o(key_input_i));
  irpmc_top #(.OSC_DIV(24'd4), .TICK_HALF(24'd4), .KEY_NR_TICKS(24'd3), .QUAL_TICKS(24'd5)) dut (.*,
    .int_enable_set_i(stb[0]), .int_enable_clr_i(stb[1]), .wide_stack_pointer_wr_i(stb[2]),
    .narrow_stack_pointer_wr_i(stb[3]), .extension_register_wr_i(stb[4]), .instr_done_i(stb[5]),
    .core_supply_wr_i(stb[6]), .lsr_halver_wr_i(stb[7]), .lcd_halver_wr_i(stb[8]), .lcd_ctrl_wr_i(stb[9]));
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // ----------------------------------------
  // checking
  // ----------------------------------------
  task check(input logic [27:0] seen, input logic [27:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  always @(negedge sys_clk_i) if (q.size() > 0) check({pc_start_o, init_reset_o, int_enable_o, int_unmask_o,
    extension_flag_o, core_supply_rail_high_o, lsr_halver_o, lcd_halver_o, lcd_base_voltage_on_o,
    lcd_base_voltage_level_o}, q.pop_front());
  task put;
    q.push_back({16'h0110, e});
    @(posedge sys_clk_i);
    #1;
  endtask
  task finish_test;
    $display("mismatches %0d comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test;
    end
  end
  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task fw(input logic [9:0] mask);
    stb = mask;
    @(posedge sys_clk_i);
    #1 stb = 10'h000;
    @(posedge sys_clk_i);
    #1;
  endtask
  task wait_ir(input logic v);
    int i;
    for (i = 0; i < 150 && init_reset_o !== v; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    seed = 5;
    {rst_n_i, stb, osc_running_i, high_speed_active_i, core_supply_high_i} = 0;
    {lsr_halver_i, lcd_halver_i, lcd_on_i, lcd_level_i, key_combo_sel_i} = 0;
    osc_running_i = 1'b1;
    repeat (5) @(posedge sys_clk_i);
    #1 rst_n_i = 1'b1;
    wait_ir(1'b0);
    e = 12'h000;
    put;
    fw(10'h011); e[10] = 1'b1; e[8] = 1'b1; put;
    fw(10'h020); e[8] = 1'b0; put;
    fw(10'h002); e[10] = 1'b0; put;
    fw(10'h004); put;
    fw(10'h008); e[9] = 1'b1; put;
    fw(10'h004); e[9] = 1'b0; put;
    fw(10'h00C); e[9] = 1'b1; put;
    {high_speed_active_i, lsr_halver_i, lcd_halver_i} = 3'h7;
    fw(10'h180); put;
    high_speed_active_i = 1'b0;
    fw(10'h080); e[6] = 1'b1; put;
    fw(10'h100); e[5] = 1'b1; put;
    core_supply_high_i = 1'b1;
    fw(10'h040); e[7] = 1'b1; put;
    for (s = 0; s < 4; s++) begin
      lcd_level_i = 4'($random(seed));
      lcd_on_i = s[0];
      fw(10'h200); e[4:0] = {lcd_on_i, lcd_level_i}; put;
    end
    m.pin(1'b1, 5);
    m.pin(1'b0, 40); put;
    m.pin(1'b1, 40); e = 12'h800; put;
    m.pin(1'b0, 1);
    wait_ir(1'b0); e = 12'h000; put;
    for (s = 1; s < 4; s++) begin
      key_combo_sel_i = s[1:0];
      km = 4'((2 << s) - 1);
      m.keys(km, 20);
      m.keys(4'h0, 4); put;
      m.keys(km | (4'($random(seed)) & ~km), 60); e = 12'h800; put;
      m.keys(4'h0, 1);
      wait_ir(1'b0); e = 12'h000; put;
    end
    osc_running_i = 1'b0;
    m.keys(4'hF, 60);
    m.keys(4'h0, 1); put;
    osc_running_i = 1'b1;
    key_combo_sel_i = 2'h0;
    m.keys(4'hF, 80);
    m.keys(4'h0, 1); put;
    finish_test;
  end
endmodule // tb_initial_reset_and_power_mode_control
